/* ctx_pkg.sv */
// package for the transmit dma channel context memory
// shared by the context block and its bus slave
package ctx_pkg;

    // geometry of the context store
    localparam int CHANNELS       = 256;
    localparam int WORDS_PER_CHAN = 6;
    localparam int DEPTH          = CHANNELS * WORDS_PER_CHAN;  // 1536 dwords

    // register byte addresses
    localparam logic [11:0] SELECT_ADDR = 12'h870;  // tx_dma_context_indirect_select
    localparam logic [11:0] DATA_ADDR   = 12'h874;  // tx_dma_context_data

    // select register field positions
    localparam int SEL_CHAN_LSB = 0;
    localparam int SEL_WORD_LSB = 8;
    localparam int SEL_DIR_BIT  = 14;
    localparam int SEL_BUSY_BIT = 15;
    localparam logic [15:0] SELECT_RESET = 16'h0000;
    localparam logic [15:0] SELECT_RW_MASK = 16'h4fff;  // busy is read only

    // word selector code of the only host writable half
    localparam logic [3:0] HOST_WR_WORD = 4'h2;

    // dword 1 field positions
    localparam int D1_ON_BIT    = 0;
    localparam int D1_DQS_BIT   = 1;
    localparam int D1_CNT_LSB   = 3;
    localparam int D1_CV_BIT    = 16;
    localparam int D1_EOF_BIT   = 17;
    localparam int D1_STD_LSB   = 18;
    localparam int D1_PRI_LSB   = 20;
    localparam int D1_PIP_BIT   = 22;

    // bus response codes
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // indirect access engine states, one hot
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_MERGE = 4'b0100,
        ST_DONE  = 4'b1000
    } ind_state_t;

    // dma engine update port
    typedef struct packed {
        logic        valid;
        logic [7:0]  chan;
        logic [2:0]  dword;
        logic [31:0] data;
        logic [31:0] mask;
    } dma_wr_t;

    // dma engine read port
    typedef struct packed {
        logic       valid;
        logic [7:0] chan;
        logic [2:0] dword;
    } dma_rd_t;

    // dword index of a word selector code
    function automatic logic [2:0] word_to_dword(input logic [3:0] w);
        logic [3:0] t;
        t = w >> 1;
        return t[2:0];
    endfunction

    // flat index of a channel and dword
    function automatic logic [10:0] flat_index(input logic [7:0] ch, input logic [2:0] dw);
        logic [13:0] p;
        p = {3'h0, ch, 3'h0} - {6'h0, ch};   // ch*8 - ch = ch*7; the next line takes one more ch off for ch*6
        p = p - {6'h0, ch} + {11'h0, dw};
        return p[10:0];
    endfunction

endpackage

/* ctx_axil_slave.sv */
// axi4-lite slave holding the indirect select and data registers
// assumes one clock and a synchronous active low reset
`timescale 1ns/1ps
module ctx_axil_slave
    import ctx_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // write address and data
    input  wire logic [11:0] s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    // read channels
    input  wire logic [11:0] s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    // to the context engine
    output logic [15:0]      select_r,
    output logic [15:0]      data_r,
    output logic             start_r,
    input  wire logic        busy,
    input  wire logic        rd_load,
    input  wire logic [15:0] rd_word
);

    ////////////////////////////////////////////////////////////////////
    // write path
    logic             aw_held_r;   // address captured
    logic [11:0]      aw_addr_r;
    logic             w_held_r;    // data captured
    logic [31:0]      w_data_r;
    logic [3:0]       w_strb_r;

    wire  do_write  = aw_held_r && w_held_r && !s_bvalid;
    wire  hit_sel_w = aw_addr_r == SELECT_ADDR;
    wire  hit_dat_w = aw_addr_r == DATA_ADDR;
    // select writes ignored while busy, so a running access keeps its target
    wire  sel_take  = do_write && hit_sel_w && !busy;
    wire  dat_take  = do_write && hit_dat_w && !busy;
    wire  [15:0] wmask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    wire  [15:0] sel_new = (select_r & ~(wmask & SELECT_RW_MASK))
                         | (w_data_r[15:0] & wmask & SELECT_RW_MASK);

    // ready flags come from flops: each drops once its channel is held
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
            s_arready <= 1'b1;
        end
        else
        begin
            s_awready <= aw_held_r ? do_write : !s_awvalid;
            s_wready  <= w_held_r ? do_write : !s_wvalid;
            s_arready <= s_rvalid ? s_rready : !s_arvalid;
        end
    end

    // capture address and data in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            aw_addr_r <= 12'h000;
            w_data_r  <= 32'h0;
            w_strb_r  <= 4'h0;
        end
        else
        begin
            if (s_awvalid && !aw_held_r)
            begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_awaddr;
            end
            else if (do_write)
                aw_held_r <= 1'b0;
            if (s_wvalid && !w_held_r)
            begin
                w_held_r <= 1'b1;
                w_data_r <= s_wdata;
                w_strb_r <= s_wstrb;
            end
            else if (do_write)
                w_held_r <= 1'b0;
        end
    end

    // registers and write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            select_r <= SELECT_RESET;
            data_r   <= 16'h0000;
            start_r  <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp  <= RESP_OKAY;
        end
        else
        begin
            start_r <= sel_take && w_strb_r[1];  // a write to the top byte launches
            if (sel_take)
                select_r <= sel_new;
            if (rd_load)
                data_r <= rd_word;
            else if (dat_take)
                data_r <= (data_r & ~wmask) | (w_data_r[15:0] & wmask);
            if (do_write)
            begin
                s_bvalid <= 1'b1;
                s_bresp  <= (hit_sel_w || hit_dat_w) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_bready)
                s_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path
    wire  rd_take = s_arvalid && s_arready;
    wire  hit_sel_r = s_araddr == SELECT_ADDR;
    wire  hit_dat_r = s_araddr == DATA_ADDR;
    wire  [15:0] sel_view = {busy, select_r[14:0]};

    // single read answered one cycle after the address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_rvalid <= 1'b0;
            s_rdata  <= 32'h0;
            s_rresp  <= RESP_OKAY;
        end
        else if (rd_take)
        begin
            s_rvalid <= 1'b1;
            s_rdata  <= hit_sel_r ? {16'h0, sel_view} : hit_dat_r ? {16'h0, data_r} : 32'h0;
            s_rresp  <= (hit_sel_r || hit_dat_r) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_rready)
            s_rvalid <= 1'b0;
    end

endmodule // ctx_axil_slave

/* tx_dma_channel_context_ram.sv */
// transmit dma per channel context memory with host indirect access
// assumes the dma engine drives its ports on aclk; host over axi4-lite
`timescale 1ns/1ps
module tx_dma_channel_context_ram
    import ctx_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [11:0] s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    // axi4-lite write response
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    // axi4-lite read address
    input  wire logic [11:0] s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    // axi4-lite read data
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    // dma engine update port
    input  wire dma_wr_t     dma_wr,
    output logic             dma_wr_ready_r,
    // dma engine read port, answer one cycle later
    input  wire dma_rd_t     dma_rd,
    output logic             dma_rd_valid_r,
    output logic [31:0]      dma_rd_data_r,
    // dma event strobes on a channel
    input  wire logic        dma_error,
    input  wire logic        dma_restart,
    input  wire logic [7:0]  dma_event_chan,
    // live per channel reporting select for the engine
    input  wire logic [7:0]  cfg_chan,
    output logic             cfg_on_r,
    output logic             cfg_dqs_r
);

    ////////////////////////////////////////////////////////////////////
    // storage
    logic [31:0]     mem_r [DEPTH];
    ind_state_t      state_r;
    ind_state_t      state_nxt;
    wire             rd_load_w;            // host read word ready
    wire  [15:0]     rd_word_w;            // half picked for the host

    wire  [15:0]     select_w;
    wire  [15:0]     data_w;
    wire             start_w;
    wire             busy_w = !(state_r == ST_IDLE);

    // host target decode
    wire  [7:0]  h_chan  = select_w[SEL_CHAN_LSB +: 8];
    wire  [3:0]  h_word  = select_w[SEL_WORD_LSB +: 4];
    wire         h_read  = select_w[SEL_DIR_BIT];
    wire  [2:0]  h_dword = word_to_dword(h_word);
    wire  [10:0] h_idx   = flat_index(h_chan, h_dword);
    // unmapped word codes past dword 5 read as zero and write nothing
    wire         h_valid = h_dword < 3'(WORDS_PER_CHAN);
    // only the writable half ever reaches storage
    wire         h_wr_ok = h_word == HOST_WR_WORD;

    // host merge takes a cycle the dma cannot use
    wire         host_slot = state_r == ST_MERGE;

    // dma write decode, event channel dword 1 index
    wire  [10:0] d_idx   = flat_index(dma_wr.chan, dma_wr.dword);
    wire  [10:0] e_idx   = flat_index(dma_event_chan, 3'd1);
    wire  [10:0] c_idx   = flat_index(cfg_chan, 3'd1);
    wire  [10:0] r_idx   = flat_index(dma_rd.chan, dma_rd.dword);
    wire         d_take  = dma_wr.valid && !host_slot;
    wire         ev_take = dma_error || dma_restart;

    ////////////////////////////////////////////////////////////////////
    // register slave
    ctx_axil_slave ctx_axil_slave_i (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .s_awaddr  (s_awaddr),
        .s_awvalid (s_awvalid),
        .s_awready (s_awready),
        .s_wdata   (s_wdata),
        .s_wstrb   (s_wstrb),
        .s_wvalid  (s_wvalid),
        .s_wready  (s_wready),
        .s_bresp   (s_bresp),
        .s_bvalid  (s_bvalid),
        .s_bready  (s_bready),
        .s_araddr  (s_araddr),
        .s_arvalid (s_arvalid),
        .s_arready (s_arready),
        .s_rdata   (s_rdata),
        .s_rresp   (s_rresp),
        .s_rvalid  (s_rvalid),
        .s_rready  (s_rready),
        .select_r  (select_w),
        .data_r    (data_w),
        .start_r   (start_w),
        .busy      (busy_w),
        .rd_load   (rd_load_w),
        .rd_word   (rd_word_w)
    );

    ////////////////////////////////////////////////////////////////////
    // indirect access sequencer
    // fetch then merge so a host write never clobbers dma owned bits
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:  if (start_w) state_nxt = ST_FETCH;
            ST_FETCH: state_nxt = h_read ? ST_DONE : ST_MERGE;
            ST_MERGE: state_nxt = ST_DONE;
            ST_DONE:  state_nxt = ST_IDLE;
            default:  state_nxt = ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // host read word lands in data register as busy drops; taken from
    // storage in done so an engine write during fetch is never stale
    wire  [31:0] host_dw = h_valid ? mem_r[h_idx] : 32'h0;
    assign rd_load_w = (state_r == ST_DONE) && h_read;
    assign rd_word_w = h_word[0] ? host_dw[31:16] : host_dw[15:0];

    ////////////////////////////////////////////////////////////////////
    // storage update
    // dma fields pass through the engine's masked writes untouched here
    // unused bits simply hold whatever was last written
    always_ff @(posedge aclk)
    begin
        // merge keeps the upper half live, so no engine bits are lost
        if (host_slot && h_valid && h_wr_ok)
            mem_r[h_idx][15:0] <= data_w;
        else if (d_take)
            mem_r[d_idx] <= (mem_r[d_idx] & ~dma_wr.mask)
                          | (dma_wr.data & dma_wr.mask);
        // error clears enable, restart sets it; restart wins; an event
        // also beats a host merge, but an engine write to that dword drops it
        if (ev_take && !(d_take && d_idx == e_idx))
            mem_r[e_idx][D1_ON_BIT] <= dma_restart;
    end

    ////////////////////////////////////////////////////////////////////
    // engine facing outputs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dma_wr_ready_r <= 1'b0;
            dma_rd_valid_r <= 1'b0;
            dma_rd_data_r  <= 32'h0;
            cfg_on_r       <= 1'b0;
            cfg_dqs_r      <= 1'b0;
        end
        else
        begin
            // stall the engine during the host merge cycle
            dma_wr_ready_r <= !(state_nxt == ST_MERGE);
            dma_rd_valid_r <= dma_rd.valid;
            dma_rd_data_r  <= mem_r[r_idx];
            cfg_on_r       <= mem_r[c_idx][D1_ON_BIT];
            cfg_dqs_r      <= mem_r[c_idx][D1_DQS_BIT];
        end
    end

endmodule // tx_dma_channel_context_ram

/* ctx_asserts.sv */
// checker for the context block's bus and engine ports
// assumes one clock domain; bound to the top module below
`timescale 1ns/1ps
module ctx_asserts
    import ctx_pkg::*;
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // bus handshakes
    input wire logic        s_awvalid,
    input wire logic        s_awready,
    input wire logic        s_wvalid,
    input wire logic        s_wready,
    input wire logic        s_bvalid,
    input wire logic        s_bready,
    input wire logic [11:0] s_araddr,
    input wire logic        s_arvalid,
    input wire logic        s_arready,
    input wire logic [1:0]  s_rresp,
    input wire logic        s_rvalid,
    input wire logic        s_rready,
    // engine side
    input wire dma_rd_t     dma_rd,
    input wire logic        dma_rd_valid_r,
    input wire logic        dma_wr_ready_r,
    input wire logic        dma_error,
    input wire logic        dma_restart,
    input wire logic [7:0]  dma_event_chan,
    input wire logic [7:0]  cfg_chan,
    input wire logic        cfg_on_r
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////
    // decoded causes
    wire ar_map  = (s_araddr == SELECT_ADDR) || (s_araddr == DATA_ADDR);
    wire ev_here = (dma_event_chan == cfg_chan);  // event on the watched channel

    sequence ar_taken; s_arvalid && s_arready; endsequence
    sequence wr_taken; s_awvalid && s_awready && s_wvalid && s_wready; endsequence

    ////////////////////////////////////////////////////////////////
    // bus answers
    read_answer_a:
        assert property (ar_taken |=> s_rvalid)
        else $error("read not answered next cycle");
    read_cause_a:
        assert property ($rose(s_rvalid) |-> $past(s_arvalid && s_arready))
        else $error("read data without request");
    read_once_a:
        assert property (s_rvalid && s_rready |=> !s_rvalid)
        else $error("read data repeated");
    write_answer_a:
        assert property (wr_taken |-> ##[1:2] s_bvalid)
        else $error("write not answered");
    write_once_a:
        assert property (s_bvalid && s_bready |=> !s_bvalid)
        else $error("write response repeated");
    unmapped_err_a:
        assert property (s_arvalid && s_arready && !ar_map |=> s_rresp == RESP_SLVERR)
        else $error("unmapped read not refused");
    mapped_ok_a:
        assert property (s_arvalid && s_arready && ar_map |=> s_rresp == RESP_OKAY)
        else $error("mapped read refused");
    ////////////////////////////////////////////////////////////////
    // engine port; a merge may stall the engine one cycle only
    engine_read_a:
        assert property (dma_rd.valid |=> dma_rd_valid_r)
        else $error("engine read not answered");
    merge_short_a:
        assert property (!dma_wr_ready_r |=> dma_wr_ready_r)
        else $error("engine stalled too long");
    err_clear_a:
        assert property (dma_error && !dma_restart && ev_here |-> ##[1:3] !cfg_on_r)
        else $error("error left channel on");
    restart_set_a:
        assert property (dma_restart && ev_here |-> ##[1:3] cfg_on_r)
        else $error("restart left channel off");
endmodule // ctx_asserts

bind tx_dma_channel_context_ram ctx_asserts ctx_asserts_i (
    .aclk, .aresetn, .s_awvalid, .s_awready, .s_wvalid, .s_wready, .s_bvalid,
    .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rresp, .s_rvalid, .s_rready,
    .dma_rd, .dma_rd_valid_r, .dma_wr_ready_r, .dma_error, .dma_restart,
    .dma_event_chan, .cfg_chan, .cfg_on_r
);

/* dma_model.sv */
// engine model: full dword writes, reads and channel events
// assumes its tasks are called right after a rising edge
`timescale 1ns/1ps
module dma_model
    import ctx_pkg::*;
(
    // clock
    input wire logic        aclk,
    // update port
    output dma_wr_t         dma_wr,
    input wire logic        dma_wr_ready_r,
    // read port
    output dma_rd_t         dma_rd,
    input wire logic        dma_rd_valid_r,
    input wire logic [31:0] dma_rd_data_r,
    // channel events
    output logic            dma_error,
    output logic            dma_restart,
    output logic [7:0]      dma_event_chan
);
    int tmo;  // writes never taken

    initial
    begin
        dma_wr = '0;
        dma_rd = '0;
        dma_error = 1'b0;
        dma_restart = 1'b0;
        dma_event_chan = 8'h00;
        tmo = 0;
    end

    ////////////////////////////////////////////////////////////////
    // full dword write, held until taken by a ready edge
    task automatic put(input logic [7:0] ch, input logic [2:0] dw, input logic [31:0] d);
        int n;
        logic rdy;
        n = 0;
        dma_wr <= '{1'b1, ch, dw, d, 32'hffff_ffff};
        do
        begin
            @(negedge aclk);
            rdy = dma_wr_ready_r;
            @(posedge aclk);
            n++;
        end
        while (rdy !== 1'b1 && n < 20);
        if (rdy !== 1'b1)
            tmo++;
        // released port shows the inverse, never the stale word
        dma_wr <= '{1'b0, ~ch, ~dw, ~d, 32'h0000_0000};
        @(posedge aclk);  // idle edge between two writes
    endtask

    // one cycle read, answer sampled mid next cycle
    task automatic get(input logic [7:0] ch, input logic [2:0] dw, output logic [31:0] d);
        dma_rd <= '{1'b1, ch, dw};
        @(posedge aclk);
        dma_rd <= '{1'b0, ~ch, ~dw};
        @(negedge aclk);
        d = dma_rd_valid_r ? dma_rd_data_r : 32'hxxxx_xxxx;
        @(posedge aclk);
    endtask

    // error or restart pulse on one channel
    task automatic pulse(input logic e, input logic r, input logic [7:0] ch);
        dma_error <= e;
        dma_restart <= r;
        dma_event_chan <= ch;
        @(posedge aclk);
        dma_error <= 1'b0;
        dma_restart <= 1'b0;
        dma_event_chan <= ~ch;
    endtask
endmodule // dma_model

/* tx_dma_channel_context_ram_tb.sv */
// bench: host indirect access and engine updates of the context memory
// assumes dma_model and the bound checker are compiled alongside
`timescale 1ns/1ps
module tx_dma_channel_context_ram_tb;
    import ctx_pkg::*;

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] s_awaddr = 12'h000;
    logic        s_awvalid = 1'b0;
    logic        s_awready;
    logic [31:0] s_wdata = 32'h0000_0000;
    logic [3:0]  s_wstrb = 4'h0;
    logic        s_wvalid = 1'b0;
    logic        s_wready;
    logic [1:0]  s_bresp;
    logic        s_bvalid;
    logic        s_bready = 1'b0;
    logic [11:0] s_araddr = 12'h000;
    logic        s_arvalid = 1'b0;
    logic        s_arready;
    logic [31:0] s_rdata;
    logic [1:0]  s_rresp;
    logic        s_rvalid;
    logic        s_rready = 1'b0;
    dma_wr_t     dma_wr;
    logic        dma_wr_ready_r;
    dma_rd_t     dma_rd;
    logic        dma_rd_valid_r;
    logic [31:0] dma_rd_data_r;
    logic        dma_error;
    logic        dma_restart;
    logic [7:0]  dma_event_chan;
    logic [7:0]  cfg_chan = 8'hff;  // watched channel
    logic        cfg_on_r;
    logic        cfg_dqs_r;
    int          err_count = 0;
    int          checked = 0;
    logic [1:0]  resp;              // last response code
    logic [31:0] rd;                // last word read
    logic [31:0] e;                 // scratch expectation

    always #5 aclk = ~aclk;

    tx_dma_channel_context_ram tx_dma_channel_context_ram_i (
        .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
        .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
        .dma_wr, .dma_wr_ready_r, .dma_rd, .dma_rd_valid_r, .dma_rd_data_r,
        .dma_error, .dma_restart, .dma_event_chan, .cfg_chan, .cfg_on_r, .cfg_dqs_r
    );
    dma_model dma_model_i (
        .aclk, .dma_wr, .dma_wr_ready_r, .dma_rd, .dma_rd_valid_r,
        .dma_rd_data_r, .dma_error, .dma_restart, .dma_event_chan
    );

    ////////////////////////////////////////////////////////////////
    // verdict and comparison
    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic hang;
        err_count++;
        conclude;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    // distinct word per dword index
    function automatic logic [31:0] pat(input logic [2:0] d);
        return 32'h8421_c6a5 ^ {4{5'h00, d}};
    endfunction

    ////////////////////////////////////////////////////////////////
    // bus cycles; ready is sampled mid cycle, where it has settled
    task automatic axi_wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] st);
        int n;
        logic aw;
        logic w;
        logic b;
        n = 0;
        s_awaddr <= a;
        s_wdata <= {16'h0000, d};
        s_wstrb <= st;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do
        begin
            @(negedge aclk);
            aw = s_awvalid && s_awready;
            w = s_wvalid && s_wready;
            b = s_bvalid;
            resp = s_bresp;
            @(posedge aclk);
            if (aw)
                s_awvalid <= 1'b0;
            if (w)
                s_wvalid <= 1'b0;
            n++;
        end
        while (b !== 1'b1 && n < 30);
        s_bready <= 1'b0;
        if (b !== 1'b1)
            hang;
        @(posedge aclk);  // idle edge between two requests
    endtask

    task automatic axi_rd(input logic [11:0] a);
        int n;
        logic ar;
        logic r;
        n = 0;
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ar = s_arvalid && s_arready;
            r = s_rvalid;
            rd = s_rdata;
            resp = s_rresp;
            @(posedge aclk);
            if (ar)
                s_arvalid <= 1'b0;
            n++;
        end
        while (r !== 1'b1 && n < 30);
        s_rready <= 1'b0;
        if (r !== 1'b1)
            hang;
        @(posedge aclk);  // idle edge between two requests
    endtask

    // wait for the busy flag to drop
    task automatic poll;
        int n;
        n = 0;
        do
        begin
            axi_rd(SELECT_ADDR);
            n++;
        end
        while (rd[SEL_BUSY_BIT] !== 1'b0 && n < 30);
        if (rd[SEL_BUSY_BIT] !== 1'b0)
            hang;
    endtask

    task automatic ind_rd(input logic [7:0] ch, input logic [3:0] w);
        axi_wr(SELECT_ADDR, {4'h4, w, ch}, 4'h3);
        poll;
        axi_rd(DATA_ADDR);
    endtask

    task automatic ind_wr(input logic [7:0] ch, input logic [3:0] w, input logic [15:0] d);
        axi_wr(DATA_ADDR, d, 4'h3);
        axi_wr(SELECT_ADDR, {4'h0, w, ch}, 4'h3);
        poll;
    endtask

    // registered status needs a few edges
    task automatic settle;
        repeat (3) @(posedge aclk);
    endtask

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(SELECT_ADDR);
        chk(rd, 32'h0000_0000);
        axi_rd(12'h878);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        axi_wr(12'h878, 16'h0000, 4'h3);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        // engine fills the last and the first channel
        for (int i = 0; i < 6; i++)
        begin
            dma_model_i.put(8'hff, 3'(i), pat(3'(i)));
            dma_model_i.put(8'h00, 3'(i), ~pat(3'(i)));
        end
        // every mapped word code of the last channel
        for (int w = 0; w < 12; w++)
        begin
            ind_rd(8'hff, 4'(w));
            e = pat(3'(w / 2));
            chk(rd, {16'h0000, w[0] ? e[31:16] : e[15:0]});
        end
        e = ~pat(3'h0);
        ind_rd(8'h00, 4'h0);
        chk(rd, {16'h0000, e[15:0]});
        settle;
        chk({30'h0, cfg_dqs_r, cfg_on_r}, 32'h0);
        cfg_chan <= 8'h00;
        // host writes: only dword 1 low half may land
        ind_wr(8'h00, HOST_WR_WORD, 16'h5a5b);
        ind_wr(8'h00, 4'h3, 16'hffff);
        ind_wr(8'hff, 4'h0, 16'h1234);
        e = ~pat(3'h1);
        dma_model_i.get(8'h00, 3'h1, rd);
        chk(rd, {e[31:16], 16'h5a5b});
        e = pat(3'h0);
        ind_rd(8'hff, 4'h0);
        chk(rd, {16'h0000, e[15:0]});
        settle;
        chk({30'h0, cfg_dqs_r, cfg_on_r}, 32'h3);
        // error clears, restart sets, restart wins a tie
        dma_model_i.pulse(1'b1, 1'b0, 8'h00);
        settle;
        chk({31'h0, cfg_on_r}, 32'h0);
        dma_model_i.pulse(1'b1, 1'b1, 8'h00);
        settle;
        chk({31'h0, cfg_on_r}, 32'h1);
        // engine update while a host read is in flight
        axi_wr(SELECT_ADDR, 16'h4400, 4'h3);
        dma_model_i.put(8'h00, 3'h3, pat(3'h7));
        poll;
        chk(rd, 32'h0000_4400);
        axi_rd(DATA_ADDR);
        e = ~pat(3'h2);
        chk(rd, {16'h0000, e[15:0]});
        dma_model_i.get(8'h00, 3'h3, rd);
        chk(rd, pat(3'h7));
        chk(32'(dma_model_i.tmo), 32'h0);
        conclude;
    end
endmodule // tx_dma_channel_context_ram_tb
